// ==== rtl/tppa_consts.svh ====
`ifndef TPPA_CONSTS_SVH
`define TPPA_CONSTS_SVH
`define TPPA_IDX_CTRL 16'h19b7
`define TPPA_IDX_HIGH 16'h19bf
`define TPPA_IDX_LOW 16'h19c3
`define TPPA_IDX_STAT 16'h19c7
`define TPPA_RST_CTRL 8'h00
`define TPPA_RST_HIGH 8'h00
`define TPPA_RST_LOW 8'h00
`define TPPA_RST_PTR 10'h000
`define TPPA_B_SINGLE 0
`define TPPA_B_CONT 1
`define TPPA_B_POS 2
`define TPPA_B_NEG 3
`define TPPA_B_CHECK 4
`define TPPA_B_FORCE 5
`define TPPA_CTRL_WMASK 8'h3f
`define TPPA_CTRL_RMASK 8'h33
`define TPPA_NDF_ON 4'h9
`define TPPA_NDF_OFF 4'h6
`define TPPA_I_MASK 10'h2aa
`define TPPA_D_MASK 10'h155
`define TPPA_PTR_MAX 10'h30e
`define TPPA_GAP_FRAMES 2'h3
`define TPPA_STUFF_BYTE 8'h00
`define TPPA_FIFO_DEPTH 16
`define TPPA_RESP_OKAY 2'h0
`define TPPA_RESP_SLVERR 2'h2
`endif

// ==== rtl/tppa_pkg.sv ====
package tppa_pkg;
   typedef enum logic [2:0] {POS_PAY, POS_H1, POS_H2, POS_H3, POS_AFTER_H3} tppa_pos_t;
   typedef enum logic [2:0] {ACT_NONE, ACT_FORCE, ACT_ONE, ACT_REPEAT, ACT_NEG, ACT_POS} tppa_act_t;
   typedef enum logic [2:0] {SEL_CTRL, SEL_HIGH, SEL_LOW, SEL_STAT, SEL_NONE} tppa_sel_t;
endpackage

// ==== rtl/tppa_stream_if.sv ====
`timescale 1ns/1ps
interface tppa_stream_if #(parameter int WIDTH = 8) ();
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ==== rtl/tppa_mem.sv ====
`timescale 1ns/1ps
module tppa_mem #(parameter int WIDTH = 8, parameter int DEPTH = 16, parameter int AW = 4) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] store [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         store[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= '0;
      end else if (re) begin
         rdata <= store[raddr];
      end
   end
endmodule

// ==== rtl/tppa_fifo.sv ====
`timescale 1ns/1ps
module tppa_fifo #(parameter int WIDTH = 8, parameter int DEPTH = 16) (
   input wire logic clk,
   input wire logic arst_n,
   tppa_stream_if.snk wr,
   tppa_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] rptr_reg;
   logic [AW:0] cnt_reg;
   logic [AW:0] cnt_next;
   logic in_ready_reg;
   logic out_valid_reg;
   logic push;
   logic rd_en;
   logic [WIDTH-1:0] rdata;

   // =========================================
   // Storage
   tppa_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
      .clk(clk),
      .arst_n(arst_n),
      .we(push),
      .waddr(wptr_reg),
      .wdata(wr.data),
      .re(rd_en),
      .raddr(rptr_reg),
      .rdata(rdata)
   );

   assign push = wr.valid && in_ready_reg;
   assign rd_en = (cnt_reg != '0) && (!out_valid_reg || rd.ready);
   assign wr.ready = in_ready_reg;
   assign rd.valid = out_valid_reg;
   assign rd.data = rdata;

   always_comb begin
      cnt_next = cnt_reg;
      if (push && !rd_en) begin
         cnt_next = cnt_reg + 1'b1;
      end else if (!push && rd_en) begin
         cnt_next = cnt_reg - 1'b1;
      end
   end

   // =========================================
   // Pointers and level
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         cnt_reg <= '0;
         in_ready_reg <= 1'b1;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (rd_en) begin
            rptr_reg <= rptr_reg + 1'b1;
         end
         cnt_reg <= cnt_next;
         in_ready_reg <= (cnt_next != (AW+1)'(DEPTH));
      end
   end

   // =========================================
   // Output stage
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_valid_reg <= 1'b0;
      end else if (rd_en) begin
         out_valid_reg <= 1'b1;
      end else if (rd.ready) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule

// ==== rtl/tppa_top.sv ====
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tppa_consts.svh"
// Function
// RL1: Rising insert-negative-stuff bit carries one payload byte in the H3 slot.
// RL2: Negative stuff sends the pointer with its decrement bits inverted.
// RL3: After negative stuff the pointer drops by one and stays reduced.
// RL4: Insert-negative-stuff bit clears itself after a one is written.
// RL5: Software loads the arbitrary pointer first, then raises the single-flag bit.
// RL6: Single-flag trigger sends flag pattern 1001 in the next frame only.
// RL7: That frame carries the arbitrary ten-bit pointer in H1/H2.
// RL8: Afterwards flag returns to 0110 and the loaded pointer is kept.
// RL9: Single-flag bit clears itself after a one is written.
// RL10: Rising force bit sends arbitrary flag, SS and pointer next frame.
// RL11: Rising positive-stuff bit places one stuff byte after H3; bit self-clears.
// RL12: Positive stuff inverts increment bits, then the pointer rises by one.
// RL13: With spacing check, events wait until three event-free frames have passed.
// RL14: Each trigger is a zero-to-one change applied once at the next frame.
module tppa_top import tppa_pkg::*; (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [15:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [15:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic [7:0] IN_DATA,
   input wire logic [2:0] IN_POS,
   input wire logic IN_VALID,
   output logic IN_READY,
   output logic [7:0] OUT_DATA,
   output logic [2:0] OUT_POS,
   output logic OUT_PAYLOAD,
   output logic OUT_VALID,
   input wire logic OUT_READY
);
   logic [7:0] ctrl_reg;
   logic [7:0] arb_high_reg;
   logic [7:0] arb_low_reg;
   logic [9:0] ptr_reg;
   logic aw_hold_reg;
   logic [15:0] aw_addr_reg;
   logic w_hold_reg;
   logic [7:0] w_data_reg;
   logic w_strb_reg;
   logic do_wr;
   tppa_sel_t wr_sel;
   logic wr_ctrl;
   logic trig_one;
   logic trig_neg;
   logic trig_pos;
   logic trig_force;
   logic pend_one_reg;
   logic pend_neg_reg;
   logic pend_pos_reg;
   logic pend_force_reg;
   logic [1:0] gap_reg;
   tppa_act_t act;
   tppa_act_t frame_act_reg;
   logic [7:0] h2_reg;
   logic [9:0] arb_ptr;
   logic [9:0] ptr_tx;
   logic [3:0] flag_tx;
   logic pop;
   tppa_pos_t in_pos;
   logic [7:0] in_byte;
   tppa_stream_if #(.WIDTH(11)) in_if ();
   tppa_stream_if #(.WIDTH(11)) out_if ();

   // =========================================
   // Register decode
   function automatic tppa_sel_t reg_sel(input logic [15:0] addr);
      if (addr == (`TPPA_IDX_CTRL << 2)) begin
         return SEL_CTRL;
      end else if (addr == (`TPPA_IDX_HIGH << 2)) begin
         return SEL_HIGH;
      end else if (addr == (`TPPA_IDX_LOW << 2)) begin
         return SEL_LOW;
      end else if (addr == (`TPPA_IDX_STAT << 2)) begin
         return SEL_STAT;
      end
      return SEL_NONE;
   endfunction

   // =========================================
   // Bus write channels
   assign do_wr = aw_hold_reg && w_hold_reg && !BVALID;
   assign wr_sel = reg_sel(aw_addr_reg);
   assign wr_ctrl = do_wr && (wr_sel == SEL_CTRL) && w_strb_reg;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         AWREADY <= 1'b0;
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= 16'h0000;
      end else begin
         AWREADY <= AWVALID && !AWREADY && !aw_hold_reg && !BVALID;
         if (AWVALID && AWREADY) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= AWADDR;
         end else if (do_wr) begin
            aw_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         WREADY <= 1'b0;
         w_hold_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_strb_reg <= 1'b0;
      end else begin
         WREADY <= WVALID && !WREADY && !w_hold_reg && !BVALID;
         if (WVALID && WREADY) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= WDATA[7:0];
            w_strb_reg <= WSTRB[0];
         end else if (do_wr) begin
            w_hold_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         BVALID <= 1'b0;
         BRESP <= `TPPA_RESP_OKAY;
      end else if (do_wr) begin
         BVALID <= 1'b1;
         BRESP <= (wr_sel == SEL_NONE) ? `TPPA_RESP_SLVERR : `TPPA_RESP_OKAY;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // =========================================
   // Bus read channel
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ARREADY <= 1'b0;
         RVALID <= 1'b0;
         RDATA <= 32'h00000000;
         RRESP <= `TPPA_RESP_OKAY;
      end else begin
         ARREADY <= ARVALID && !ARREADY && !RVALID;
         if (ARVALID && ARREADY) begin
            RVALID <= 1'b1;
            RRESP <= `TPPA_RESP_OKAY;
            unique case (reg_sel(ARADDR))
               SEL_CTRL: RDATA <= {24'h000000, ctrl_reg & `TPPA_CTRL_RMASK};
               SEL_HIGH: RDATA <= {24'h000000, arb_high_reg};
               SEL_LOW: RDATA <= {24'h000000, arb_low_reg};
               SEL_STAT: RDATA <= {22'h0, ptr_reg};
               SEL_NONE: begin
                  RDATA <= 32'h00000000;
                  RRESP <= `TPPA_RESP_SLVERR;
               end
            endcase
         end else if (RREADY) begin
            RVALID <= 1'b0;
         end
      end
   end

   // =========================================
   // Control and arbitrary pointer registers
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_reg <= `TPPA_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_reg <= w_data_reg & `TPPA_CTRL_WMASK;
      end else begin
         ctrl_reg[`TPPA_B_NEG] <= 1'b0; // RL4
         ctrl_reg[`TPPA_B_POS] <= 1'b0; // RL11
         ctrl_reg[`TPPA_B_SINGLE] <= 1'b0; // RL9
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         arb_high_reg <= `TPPA_RST_HIGH;
         arb_low_reg <= `TPPA_RST_LOW;
      end else if (do_wr && w_strb_reg) begin
         if (wr_sel == SEL_HIGH) begin
            arb_high_reg <= w_data_reg; // RL5
         end
         if (wr_sel == SEL_LOW) begin
            arb_low_reg <= w_data_reg; // RL5
         end
      end
   end

   // =========================================
   // Trigger detection and pending requests
   assign trig_one = wr_ctrl && w_data_reg[`TPPA_B_SINGLE] && !ctrl_reg[`TPPA_B_SINGLE]; // RL14
   assign trig_neg = wr_ctrl && w_data_reg[`TPPA_B_NEG] && !ctrl_reg[`TPPA_B_NEG]; // RL14
   assign trig_pos = wr_ctrl && w_data_reg[`TPPA_B_POS] && !ctrl_reg[`TPPA_B_POS]; // RL14
   assign trig_force = wr_ctrl && w_data_reg[`TPPA_B_FORCE] && !ctrl_reg[`TPPA_B_FORCE]; // RL14

   assign pop = out_if.valid && out_if.ready;
   assign in_pos = tppa_pos_t'(out_if.data[10:8]);
   assign in_byte = out_if.data[7:0];

   // Pick the single event for this frame, spacing check first
   always_comb begin
      act = ACT_NONE;
      if (!ctrl_reg[`TPPA_B_CHECK] || gap_reg == `TPPA_GAP_FRAMES) begin // RL13
         if (pend_force_reg) begin
            act = ACT_FORCE; // RL10
         end else if (pend_one_reg) begin
            act = ACT_ONE; // RL6
         end else if (ctrl_reg[`TPPA_B_CONT]) begin
            act = ACT_REPEAT;
         end else if (pend_neg_reg) begin
            act = ACT_NEG; // RL1
         end else if (pend_pos_reg) begin
            act = ACT_POS; // RL11
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pend_one_reg <= 1'b0;
         pend_neg_reg <= 1'b0;
         pend_pos_reg <= 1'b0;
         pend_force_reg <= 1'b0;
      end else begin
         if (trig_one) begin
            pend_one_reg <= 1'b1;
         end else if (pop && in_pos == POS_H1 && act == ACT_ONE) begin
            pend_one_reg <= 1'b0;
         end
         if (trig_neg) begin
            pend_neg_reg <= 1'b1;
         end else if (pop && in_pos == POS_H1 && act == ACT_NEG) begin
            pend_neg_reg <= 1'b0;
         end
         if (trig_pos) begin
            pend_pos_reg <= 1'b1;
         end else if (pop && in_pos == POS_H1 && act == ACT_POS) begin
            pend_pos_reg <= 1'b0;
         end
         if (trig_force) begin
            pend_force_reg <= 1'b1;
         end else if (pop && in_pos == POS_H1 && act == ACT_FORCE) begin
            pend_force_reg <= 1'b0;
         end
      end
   end

   // =========================================
   // Pointer word for the current frame
   assign arb_ptr = {arb_high_reg[1:0], arb_low_reg}; // RL7

   always_comb begin
      ptr_tx = ptr_reg;
      flag_tx = `TPPA_NDF_OFF; // RL8
      unique case (act)
         ACT_NONE: ptr_tx = ptr_reg;
         ACT_FORCE: begin
            ptr_tx = arb_ptr; // RL10
            flag_tx = arb_high_reg[7:4]; // RL10
         end
         ACT_ONE, ACT_REPEAT: begin
            ptr_tx = arb_ptr; // RL7
            flag_tx = `TPPA_NDF_ON; // RL6
         end
         ACT_NEG: ptr_tx = ptr_reg ^ `TPPA_D_MASK; // RL2
         ACT_POS: ptr_tx = ptr_reg ^ `TPPA_I_MASK; // RL12
         default: ptr_tx = ptr_reg;
      endcase
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ptr_reg <= `TPPA_RST_PTR;
         gap_reg <= `TPPA_GAP_FRAMES;
         frame_act_reg <= ACT_NONE;
         h2_reg <= 8'h00;
      end else if (pop && in_pos == POS_H1) begin
         frame_act_reg <= act;
         h2_reg <= ptr_tx[7:0];
         gap_reg <= (act != ACT_NONE) ? 2'h0 :
                    (gap_reg == `TPPA_GAP_FRAMES) ? gap_reg : gap_reg + 2'h1; // RL13
         unique case (act)
            ACT_FORCE, ACT_ONE, ACT_REPEAT: ptr_reg <= arb_ptr; // RL8
            ACT_NEG: ptr_reg <= (ptr_reg == 10'h000) ? `TPPA_PTR_MAX : ptr_reg - 10'h001; // RL3
            ACT_POS: ptr_reg <= (ptr_reg == `TPPA_PTR_MAX) ? 10'h000 : ptr_reg + 10'h001; // RL12
            ACT_NONE: ptr_reg <= ptr_reg;
            default: ptr_reg <= ptr_reg;
         endcase
      end
   end

   // =========================================
   // Outbound byte stream
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         OUT_VALID <= 1'b0;
         OUT_DATA <= 8'h00;
         OUT_POS <= 3'h0;
         OUT_PAYLOAD <= 1'b0;
      end else if (pop) begin
         OUT_VALID <= 1'b1;
         OUT_POS <= out_if.data[10:8];
         OUT_DATA <= in_byte;
         OUT_PAYLOAD <= 1'b1;
         unique case (in_pos)
            POS_H1: begin
               OUT_DATA <= {flag_tx, arb_high_reg[3:2], ptr_tx[9:8]};
               OUT_PAYLOAD <= 1'b0;
            end
            POS_H2: begin
               OUT_DATA <= h2_reg;
               OUT_PAYLOAD <= 1'b0;
            end
            POS_H3: begin
               OUT_DATA <= (frame_act_reg == ACT_NEG) ? in_byte : `TPPA_STUFF_BYTE; // RL1
               OUT_PAYLOAD <= (frame_act_reg == ACT_NEG); // RL1
            end
            POS_AFTER_H3: begin
               OUT_DATA <= (frame_act_reg == ACT_POS) ? `TPPA_STUFF_BYTE : in_byte; // RL11
               OUT_PAYLOAD <= (frame_act_reg != ACT_POS); // RL11
            end
            POS_PAY: OUT_DATA <= in_byte;
            default: OUT_PAYLOAD <= 1'b0;
         endcase
      end else if (OUT_READY) begin
         OUT_VALID <= 1'b0;
      end
   end

   // =========================================
   // Input buffering
   assign in_if.data = {IN_POS, IN_DATA};
   assign in_if.valid = IN_VALID;
   assign IN_READY = in_if.ready;
   assign out_if.ready = !OUT_VALID || OUT_READY;

   tppa_fifo #(.WIDTH(11), .DEPTH(`TPPA_FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .arst_n(ARST_N),
      .wr(in_if.snk),
      .rd(out_if.src)
   );
endmodule

// ==== testbench/tppa_top_sva.sv ====
`timescale 1ns/1ps
// ==========
// Port checks
module tppa_top_sva (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic [1:0] BRESP,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic [31:0] RDATA,
   input wire logic RVALID,
   input wire logic RREADY,
   input wire logic [7:0] OUT_DATA,
   input wire logic [2:0] OUT_POS,
   input wire logic OUT_PAYLOAD,
   input wire logic OUT_VALID,
   input wire logic OUT_READY
);
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   sequence s_write_taken;
      WVALID && WREADY;
   endsequence
   sequence s_read_taken;
      ARVALID && ARREADY;
   endsequence
   sequence s_h1_sent;
      OUT_VALID && OUT_READY && OUT_POS == 3'd1;
   endsequence
   a_aw_ready_pulse: assert property (AWREADY |=> !AWREADY)
      else $error("awready held too long");
   a_write_answer: assert property (s_write_taken |-> ##[1:4] BVALID)
      else $error("no write response");
   a_bvalid_holds: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped");
   a_read_answer: assert property (s_read_taken |=> RVALID)
      else $error("no read response");
   a_rdata_holds: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
      else $error("read data dropped");
   a_out_holds: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable({OUT_DATA, OUT_POS, OUT_PAYLOAD}))
      else $error("outbound byte dropped");
   a_h3_idle_zero: assert property (OUT_VALID && OUT_POS == 3'd3 && !OUT_PAYLOAD |-> OUT_DATA == 8'h00)
      else $error("idle h3 not zero");
   a_stuff_byte_zero: assert property (OUT_VALID && OUT_POS == 3'd4 && !OUT_PAYLOAD |-> OUT_DATA == 8'h00)
      else $error("stuff byte not zero");
   a_h1_then_h2: assert property (s_h1_sent |-> ##[1:30] (OUT_VALID && OUT_POS == 3'd2 && !OUT_PAYLOAD))
      else $error("h2 missing after h1");
endmodule
bind tppa_top tppa_top_sva tppa_top_sva_inst (.CLK(CLK), .ARST_N(ARST_N), .AWREADY(AWREADY), .WVALID(WVALID),
   .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID), .ARREADY(ARREADY),
   .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY), .OUT_DATA(OUT_DATA), .OUT_POS(OUT_POS),
   .OUT_PAYLOAD(OUT_PAYLOAD), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY));

// ==== testbench/tppa_sink.sv ====
`timescale 1ns/1ps
// ==========
// Downstream stage model
module tppa_sink (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] out_data,
   input wire logic [2:0] out_pos,
   input wire logic out_payload,
   input wire logic out_valid,
   input wire logic slow,
   input wire logic hold,
   output logic out_ready
);
   logic [11:0] got[$];
   logic [1:0] phase_reg;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_reg <= 2'h0;
         out_ready <= 1'b0;
      end else begin
         phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
         out_ready <= !hold && (!slow || phase_reg == 2'h2);
         if (out_valid && out_ready)
            got.push_back({out_pos, out_payload, out_data});
      end
   end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
`include "tppa_consts.svh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("unexpected at %0t: %h not %h", $time, a, e); end end
// ==========
// Bench
module tb;
   localparam logic [15:0] A_CTRL = 16'(`TPPA_IDX_CTRL * 4);
   localparam logic [15:0] A_HIGH = 16'(`TPPA_IDX_HIGH * 4);
   localparam logic [15:0] A_LOW = 16'(`TPPA_IDX_LOW * 4);
   localparam logic [15:0] A_STAT = 16'(`TPPA_IDX_STAT * 4);
   localparam logic [1:0] OK = `TPPA_RESP_OKAY;
   localparam logic [1:0] ERR = `TPPA_RESP_SLVERR;
   localparam logic [9:0] D = `TPPA_D_MASK;
   localparam logic [9:0] I = `TPPA_I_MASK;
   logic clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, in_ready, out_payload, out_valid, out_ready;
   logic [1:0] bresp, rresp;
   logic [7:0] in_data = 8'h00, out_data;
   logic [2:0] in_pos = 3'h0, out_pos;
   logic in_valid = 1'b0, slow = 1'b0, hold = 1'b0;
   int fails = 0, total_checks = 0, cycles = 0;
   always #50 clk = ~clk;
   tppa_top tppa_top_inst (.CLK(clk), .ARST_N(arst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .IN_DATA(in_data), .IN_POS(in_pos), .IN_VALID(in_valid),
      .IN_READY(in_ready), .OUT_DATA(out_data), .OUT_POS(out_pos), .OUT_PAYLOAD(out_payload),
      .OUT_VALID(out_valid), .OUT_READY(out_ready));
   tppa_sink tppa_sink_inst (.clk(clk), .arst_n(arst_n), .out_data(out_data), .out_pos(out_pos),
      .out_payload(out_payload), .out_valid(out_valid), .slow(slow), .hold(hold), .out_ready(out_ready));
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("unexpected at %0t: run too long", $time);
         summarize();
      end
   end
   task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1 && bready !== 1'b1) bready <= 1'b1;
      end while ((bvalid !== 1'b1 || bready !== 1'b1) && n < 100);
      bready <= 1'b0;
      `CHK({bvalid, bready, bresp}, {2'b11, er})
      @(posedge clk);
   endtask
   task automatic rdc(input logic [15:0] a, input logic [9:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1 && rready !== 1'b1) rready <= 1'b1;
      end while ((rvalid !== 1'b1 || rready !== 1'b1) && n < 100);
      rready <= 1'b0;
      `CHK({rvalid, rready, rresp, rdata}, {2'b11, er, 22'h0, ed})
      @(posedge clk);
   endtask
   task automatic push(input logic [2:0] p, input logic [7:0] d);
      int n;
      n = 0;
      in_data <= d;
      in_pos <= p;
      in_valid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (in_ready !== 1'b1 && n < 500);
      `CHK(in_ready, 1'b1)
   endtask
   // One frame of header slots and a payload byte, then the outbound bytes are judged
   task automatic frame(input logic [3:0] f, input logic [1:0] ss, input logic [9:0] sent, input int kind);
      int base, n;
      base = tppa_sink_inst.got.size();
      n = 0;
      push(3'd1, 8'hc1);
      push(3'd2, 8'hc2);
      push(3'd3, 8'ha3);
      push(3'd4, 8'ha4);
      push(3'd0, 8'h5a);
      in_valid <= 1'b0;
      while (tppa_sink_inst.got.size() < base + 5 && n < 300) begin
         @(posedge clk);
         n++;
      end
      `CHK(tppa_sink_inst.got[base], {3'd1, 1'b0, f, ss, sent[9:8]})
      `CHK(tppa_sink_inst.got[base + 1], {3'd2, 1'b0, sent[7:0]})
      `CHK(tppa_sink_inst.got[base + 2], (kind == 1) ? {3'd3, 1'b1, 8'ha3} : {3'd3, 1'b0, 8'h00})
      `CHK(tppa_sink_inst.got[base + 3], (kind == 2) ? {3'd4, 1'b0, 8'h00} : {3'd4, 1'b1, 8'ha4})
      `CHK(tppa_sink_inst.got[base + 4], {3'd0, 1'b1, 8'h5a})
   endtask
   task automatic t_regs();
      rdc(A_CTRL, 10'h000, OK);
      rdc(A_HIGH, 10'h000, OK);
      rdc(A_LOW, 10'h000, OK);
      wr(A_CTRL, 8'hd0, OK);
      rdc(A_CTRL, 10'h010, OK);
      wr(A_CTRL, 8'h00, OK);
      wr(16'h0000, 8'h55, ERR);
      rdc(16'h0000, 10'h000, ERR);
      wr(A_STAT, 8'h77, OK);
      rdc(A_STAT, 10'h000, OK);
      frame(`TPPA_NDF_OFF, 2'b00, 10'h000, 0);
      $display("regs done");
   endtask
   task automatic t_single();
      wr(A_HIGH, 8'h05, OK);
      wr(A_LOW, 8'ha5, OK);
      rdc(A_HIGH, 10'h005, OK);
      wr(A_CTRL, 8'h01, OK);
      rdc(A_CTRL, 10'h000, OK);
      frame(`TPPA_NDF_ON, 2'b01, 10'h1a5, 0);
      frame(`TPPA_NDF_OFF, 2'b01, 10'h1a5, 0);
      rdc(A_STAT, 10'h1a5, OK);
      wr(A_CTRL, 8'h02, OK);
      repeat (2) frame(`TPPA_NDF_ON, 2'b01, 10'h1a5, 0);
      wr(A_CTRL, 8'h00, OK);
      frame(`TPPA_NDF_OFF, 2'b01, 10'h1a5, 0);
      $display("single done");
   endtask
   task automatic t_stuff();
      slow <= 1'b1;
      wr(A_CTRL, 8'h08, OK);
      rdc(A_CTRL, 10'h000, OK);
      frame(`TPPA_NDF_OFF, 2'b01, 10'h1a5 ^ D, 1);
      frame(`TPPA_NDF_OFF, 2'b01, 10'h1a4, 0);
      rdc(A_STAT, 10'h1a4, OK);
      wr(A_CTRL, 8'h04, OK);
      rdc(A_CTRL, 10'h000, OK);
      frame(`TPPA_NDF_OFF, 2'b01, 10'h1a4 ^ I, 2);
      frame(`TPPA_NDF_OFF, 2'b01, 10'h1a5, 0);
      slow <= 1'b0;
      $display("stuff done");
   endtask
   task automatic t_force();
      wr(A_HIGH, 8'hae, OK);
      wr(A_LOW, 8'h0c, OK);
      wr(A_CTRL, 8'h20, OK);
      rdc(A_CTRL, 10'h020, OK);
      frame(4'ha, 2'b11, 10'h20c, 0);
      frame(`TPPA_NDF_OFF, 2'b11, 10'h20c, 0);
      wr(A_CTRL, 8'h10, OK);
      repeat (3) frame(`TPPA_NDF_OFF, 2'b11, 10'h20c, 0);
      wr(A_CTRL, 8'h18, OK);
      frame(`TPPA_NDF_OFF, 2'b11, 10'h20c ^ D, 1);
      wr(A_CTRL, 8'h14, OK);
      repeat (3) frame(`TPPA_NDF_OFF, 2'b11, 10'h20b, 0);
      frame(`TPPA_NDF_OFF, 2'b11, 10'h20b ^ I, 2);
      frame(`TPPA_NDF_OFF, 2'b11, 10'h20c, 0);
      wr(A_CTRL, 8'h00, OK);
      $display("force and spacing done");
   endtask
   task automatic t_fifo();
      int k, base, n;
      k = 0;
      n = 0;
      base = tppa_sink_inst.got.size();
      hold <= 1'b1;
      in_pos <= 3'd0;
      in_data <= 8'h00;
      in_valid <= 1'b1;
      do begin
         @(posedge clk);
         if (in_ready === 1'b1) begin
            k++;
            in_data <= 8'(k);
         end
      end while (in_ready === 1'b1 && k < 40);
      in_valid <= 1'b0;
      `CHK(k >= `TPPA_FIFO_DEPTH && k <= `TPPA_FIFO_DEPTH + 3, 1'b1)
      hold <= 1'b0;
      while (tppa_sink_inst.got.size() < base + k && n < 300) begin
         @(posedge clk);
         n++;
      end
      for (int i = 0; i < k; i++)
         `CHK(tppa_sink_inst.got[base + i], {3'd0, 1'b1, 8'(i)})
      `CHK(in_ready, 1'b1)
      $display("fifo done");
   endtask
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_single();
      t_stuff();
      t_force();
      t_fifo();
      summarize();
   end
endmodule
